// *** hw/pes_event_sense_mask.sv ***
// event sense, latch and mask logic with its two-wire serial register slave
// assumes the live conditions and bus lines are asynchronous pins; one clock
`timescale 1ns/1ps
module pes_event_sense_mask #(
   parameter logic [6:0] DEV_ADDR = 7'h10   // 7-bit bus address
) (
   input  wire logic                   CLK,
   input  wire logic                   RST,
   input  wire pes_pkg::pes_sense_type SENSE_IN,
   input  wire logic                   SCL_IN,
   input  wire logic                   SDA_IN,
   output logic                        SDA_OUT,
   output logic                        SDA_OE_N,
   output logic                        INT_N
);

   // synchroniser chain: 16 senses, clock line, data line
   logic [17:0] raw;          // unsynchronised pins
   logic [17:0] sync1;        // first stage, read only by sync2
   logic [17:0] sync2;        // second stage
   logic [17:0] sync3;        // third stage
   logic [17:0] stab;         // accepted level

   // live status and latched events
   logic [15:0] sense_q;      // live status as read back
   logic [15:0] evt;          // one-cycle change pulses
   logic [15:0] ack;          // latched events
   logic [15:0] clr;          // read-clear strobe per bit
   logic [15:0] next_ack;     // next latched events
   logic [15:0] mask;         // source gates, 1 masks
   logic [15:0] pending;      // unmasked pending events

   // serial slave
   pes_pkg::pes_bus_state_type state;    // sequencer state
   logic        scl;          // filtered clock line
   logic        sda;          // filtered data line
   logic        scl_q;        // clock line one cycle ago
   logic        sda_q;        // data line one cycle ago
   logic        scl_rise;     // sampling edge
   logic        scl_fall;     // drive edge
   logic        bus_start;    // start or repeated start
   logic        bus_stop;     // stop condition
   logic [3:0]  cnt;          // bits taken in this byte
   logic [7:0]  shift;        // received byte
   logic [7:0]  tx;           // byte being sent
   logic [7:0]  ptr;          // register pointer
   logic [7:0]  rd_data;      // register at pointer
   logic        rw;           // transfer direction
   logic        nack;         // master refused the last byte
   logic        drive_low;    // pull data line low
   logic        wr_stb;       // write byte complete
   logic        ld_stb;       // read byte loaded for sending

   // general-call and reserved bus addresses cannot be served by this slave
   if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
      $error("slave address outside the usable range");
   end

   assign raw = {SDA_IN, SCL_IN, SENSE_IN & pes_pkg::LIVE_USED};

   // four flops per pin; a change counts once stages two and three agree
   for (genvar g = 0; g < 18; g++) begin : g_sync
      always_ff @(posedge CLK) begin
         if (RST) begin
            sync1[g] <= pes_pkg::SYNC_RST[g];
            sync2[g] <= pes_pkg::SYNC_RST[g];
            sync3[g] <= pes_pkg::SYNC_RST[g];
            stab[g]  <= pes_pkg::SYNC_RST[g];
         end else begin
            sync1[g] <= raw[g];
            sync2[g] <= sync1[g];
            sync3[g] <= sync2[g];
            if (sync2[g] == sync3[g]) begin
               stab[g] <= sync3[g];   // disagreement keeps the old level
            end
         end
      end
   end

   assign scl = stab[16];
   assign sda = stab[17];

   // live status follows the pins, never latched
   always_ff @(posedge CLK) begin
      if (RST) begin
         sense_q <= {pes_pkg::RST_STATUS, pes_pkg::RST_STATUS};
      end else begin
         sense_q <= stab[15:0];   // RULE20
      end
   end

   // either edge of a live level is an event
   assign evt = (stab[15:0] ^ sense_q) & pes_pkg::LIVE_USED;   // RULE19

   // reading an event register clears the whole byte as it is sent
   always_comb begin
      clr = 16'h0000;
      if (ld_stb && ptr == pes_pkg::OFF_EVENT_ONE) begin
         clr[15:8] = 8'hFF;
      end
      if (ld_stb && ptr == pes_pkg::OFF_EVENT_TWO) begin
         clr[7:0] = 8'hFF;
      end
   end

   // set beats clear so an edge during the read is kept for the next read
   assign next_ack = (ack & ~clr) | evt;   // RULE19

   // latched events
   always_ff @(posedge CLK) begin
      if (RST) begin
         ack <= {pes_pkg::RST_EVENT, pes_pkg::RST_EVENT};
      end else begin
         ack <= next_ack;   // RULE1 RULE2 RULE3 RULE4 RULE5
      end
   end

   // mask registers, written over the bus; the spare bit is kept as written
   always_ff @(posedge CLK) begin
      if (RST) begin
         mask <= {pes_pkg::RST_MASK, pes_pkg::RST_MASK};   // RULE17
      end else if (wr_stb && ptr == pes_pkg::OFF_MASK_ONE) begin
         mask[15:8] <= shift;   // RULE15 RULE16 RULE17
      end else if (wr_stb && ptr == pes_pkg::OFF_MASK_TWO) begin
         mask[7:0] <= shift;    // RULE18
      end
   end

   // interrupt line, active low, registered
   assign pending = ack & ~mask;
   always_ff @(posedge CLK) begin
      if (RST) begin
         INT_N <= 1'b1;
      end else begin
         INT_N <= ~|pending;   // RULE21
      end
   end

   // register read mux; unmapped offsets read as zero
   always_comb begin
      unique case (ptr)
         pes_pkg::OFF_EVENT_ONE:  rd_data = ack[15:8];
         pes_pkg::OFF_EVENT_TWO:  rd_data = ack[7:0];
         pes_pkg::OFF_STATUS_ONE: rd_data = sense_q[15:8];   // RULE6 RULE7 RULE8 RULE9
         pes_pkg::OFF_STATUS_TWO: rd_data = sense_q[7:0];    // RULE10 RULE11 RULE12 RULE13 RULE14
         pes_pkg::OFF_MASK_ONE:   rd_data = mask[15:8];
         pes_pkg::OFF_MASK_TWO:   rd_data = mask[7:0];
         default:                 rd_data = pes_pkg::READ_UNMAPPED;
      endcase
   end

   // bus line edges and conditions
   always_ff @(posedge CLK) begin
      if (RST) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   assign scl_rise  = scl & ~scl_q;
   assign scl_fall  = ~scl & scl_q;
   assign bus_start = scl & scl_q & sda_q & ~sda;
   assign bus_stop  = scl & scl_q & ~sda_q & sda;
   assign wr_stb    = (state == pes_pkg::ST_WDATA) && scl_fall
                      && cnt == pes_pkg::BITS_PER_BYTE;
   assign ld_stb    = scl_fall && ((state == pes_pkg::ST_ADDR_ACK && rw == pes_pkg::BUS_READ)
                      || (state == pes_pkg::ST_RACK && !nack));

   // serial slave sequencer: sample on rising clock, drive on falling clock
   always_ff @(posedge CLK) begin
      if (RST) begin
         state     <= pes_pkg::ST_IDLE;
         cnt       <= 4'h0;
         shift     <= 8'h00;
         tx        <= 8'h00;
         ptr       <= 8'h00;
         rw        <= 1'b0;
         nack      <= 1'b0;
         drive_low <= 1'b0;
      end else if (bus_start) begin
         state     <= pes_pkg::ST_ADDR;   // repeated start keeps the pointer
         cnt       <= 4'h0;
         drive_low <= 1'b0;
      end else if (bus_stop) begin
         state     <= pes_pkg::ST_IDLE;
         drive_low <= 1'b0;
      end else begin
         if (scl_rise && state != pes_pkg::ST_TX) begin
            shift <= {shift[6:0], sda};
            cnt   <= cnt + 4'h1;
            if (state == pes_pkg::ST_RACK) begin
               nack <= sda;   // high means the master wants no more
            end
         end else if (scl_rise) begin
            cnt <= cnt + 4'h1;
         end
         if (scl_fall) begin
            unique case (state)
               pes_pkg::ST_IDLE: begin
                  drive_low <= 1'b0;
               end
               pes_pkg::ST_ADDR: begin
                  if (cnt == pes_pkg::BITS_PER_BYTE) begin
                     if (shift[7:1] == DEV_ADDR) begin
                        rw        <= shift[0];
                        drive_low <= 1'b1;   // acknowledge the address
                        state     <= pes_pkg::ST_ADDR_ACK;
                     end else begin
                        state <= pes_pkg::ST_IDLE;   // not ours, stay silent
                     end
                  end
               end
               pes_pkg::ST_ADDR_ACK, pes_pkg::ST_RACK: begin
                  cnt <= 4'h0;
                  if (state == pes_pkg::ST_ADDR_ACK && rw != pes_pkg::BUS_READ) begin
                     drive_low <= 1'b0;
                     state     <= pes_pkg::ST_REG;
                  end else if (state == pes_pkg::ST_RACK && nack) begin
                     drive_low <= 1'b0;
                     state     <= pes_pkg::ST_IDLE;
                  end else begin
                     tx        <= rd_data;
                     drive_low <= ~rd_data[7];
                     ptr       <= ptr + 8'h01;   // auto-increment
                     state     <= pes_pkg::ST_TX;
                  end
               end
               pes_pkg::ST_REG, pes_pkg::ST_WDATA: begin
                  if (cnt == pes_pkg::BITS_PER_BYTE) begin
                     drive_low <= 1'b1;
                     state     <= pes_pkg::ST_WR_ACK;
                     if (state == pes_pkg::ST_REG) begin
                        ptr <= shift;
                     end else begin
                        ptr <= ptr + 8'h01;   // byte written this edge
                     end
                  end
               end
               pes_pkg::ST_WR_ACK: begin
                  drive_low <= 1'b0;
                  cnt       <= 4'h0;
                  state     <= pes_pkg::ST_WDATA;
               end
               pes_pkg::ST_TX: begin
                  if (cnt == pes_pkg::BITS_PER_BYTE) begin
                     drive_low <= 1'b0;   // let the master acknowledge
                     state     <= pes_pkg::ST_RACK;
                  end else begin
                     tx        <= {tx[6:0], 1'b0};
                     drive_low <= ~tx[6];
                  end
               end
            endcase
         end
      end
   end

   assign SDA_OUT  = 1'b0;         // open drain: only ever pulls low
   assign SDA_OE_N = ~drive_low;   // low while pulling the line

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_status_one_read;
      ld_stb && ptr == pes_pkg::OFF_STATUS_ONE;
   endsequence

   sequence s_status_two_read;
      ld_stb && ptr == pes_pkg::OFF_STATUS_TWO;
   endsequence

   property p_buck_oc;
      $changed(sense_q[pes_pkg::POS_BUCK_OC]) |-> ack[pes_pkg::POS_BUCK_OC];
   endproperty
   a_buck_oc: assert property (p_buck_oc) else $error("buck overcurrent event lost"); // RULE1

   property p_reg_oc;
      $changed(sense_q[4:1]) |-> (ack[4:1] & (sense_q[4:1] ^ $past(sense_q[4:1])))
         == (sense_q[4:1] ^ $past(sense_q[4:1]));
   endproperty
   a_reg_oc: assert property (p_reg_oc) else $error("regulator overcurrent event lost"); // RULE2

   property p_underv;
      $changed(sense_q[pes_pkg::POS_UNDERV]) |-> ack[pes_pkg::POS_UNDERV];
   endproperty
   a_underv: assert property (p_underv) else $error("undervoltage event lost"); // RULE3

   // a read-clear loaded in the cycle after the edge may legally drop the bit
   property p_twarn;
      $rose(sense_q[pes_pkg::POS_TWARN]) |-> ack[pes_pkg::POS_TWARN]
         ##1 (ack[pes_pkg::POS_TWARN] || $past(clr[pes_pkg::POS_TWARN]));
   endproperty
   a_twarn: assert property (p_twarn) else $error("thermal warning event lost"); // RULE4

   property p_tshut;
      $fell(sense_q[pes_pkg::POS_TSHUT]) |-> ack[pes_pkg::POS_TSHUT];
   endproperty
   a_tshut: assert property (p_tshut) else $error("thermal shutdown event lost"); // RULE5

   property p_status_one;
      s_status_one_read |=> tx == $past(sense_q[15:8]) && !tx[5];
   endproperty
   a_status_one: assert property (p_status_one) else $error("status one wrong"); // RULE8

   property p_status_two;
      s_status_two_read |=> tx == $past(sense_q[7:0]);
   endproperty
   a_status_two: assert property (p_status_two) else $error("status two wrong"); // RULE11

   property p_mask_reset;
      $past(RST) |-> mask == 16'hFFFF && INT_N;
   endproperty
   a_mask_reset: assert property (p_mask_reset) else $error("masks not all ones"); // RULE17

   property p_read_clear;
      (ld_stb && ptr == pes_pkg::OFF_EVENT_TWO) |=> ack[7:0] == $past(evt[7:0]);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // RULE19

   property p_irq;
      1 |=> INT_N == !$past(|(ack & ~mask));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt line wrong"); // RULE21

   // a completed write byte lands in the addressed mask only
   property p_mask1_wr;
      (wr_stb && ptr == pes_pkg::OFF_MASK_ONE) |=> mask[15:8] == $past(shift);
   endproperty
   a_mask1_wr: assert property (p_mask1_wr) else $error("mask one not written"); // RULE15

   // second mask byte gates the fault sources
   property p_mask2_wr;
      (wr_stb && ptr == pes_pkg::OFF_MASK_TWO) |=> mask[7:0] == $past(shift);
   endproperty
   a_mask2_wr: assert property (p_mask2_wr) else $error("mask two not written"); // RULE18

   // an unmasked clock-valid event alone is enough to pull the line
   property p_clk_ok_gate;
      (ack[pes_pkg::POS_CLK_OK] && !mask[pes_pkg::POS_CLK_OK]) |=> !INT_N;
   endproperty
   a_clk_ok_gate: assert property (p_clk_ok_gate) else $error("clock event ignored"); // RULE16

endmodule : pes_event_sense_mask

// *** hw/pes_pkg.sv ***
// constants, types and the register map of the event sense and mask block
// assumes a single 40 MHz clock and a synchronous active-high reset
//
// Overview of operation
// RULE1: buck overcurrent change sets its latched event bit
// RULE2: each regulator overcurrent change sets own event bit
// RULE3: undervoltage change sets its latched event bit
// RULE4: thermal warning change sets its latched event bit
// RULE5: thermal shutdown change sets its latched event bit
// RULE6: status one bit0 shows live buck power-good
// RULE7: status one bits1-4 show regulator power-good
// RULE8: bit6 shows clock valid; bit5 reads zero
// RULE9: status one bit7 shows external clock in use
// RULE10: status two bit0 shows buck overcurrent live
// RULE11: status two bits1-4 show regulator overcurrent live
// RULE12: status two bit5 shows input undervoltage live
// RULE13: status two bit6 shows thermal warning live
// RULE14: status two bit7 shows thermal shutdown live
// RULE15: mask one bits0-4 gate power-good sources
// RULE16: mask one bit6 gates clock-valid source
// RULE17: mask one bit7 gates clock-select; masks reset FF
// RULE18: mask two bits gate matching fault sources
// RULE19: event bits latch both edges, clear on read
// RULE20: status registers are live, read-only, never latched
// RULE21: interrupt asserted while any unmasked event pending
// RULE22: host reads events after interrupt to clear them
package pes_pkg;

   // register offsets on the serial bus
   localparam logic [7:0] OFF_EVENT_ONE  = 8'h20;
   localparam logic [7:0] OFF_EVENT_TWO  = 8'h21;
   localparam logic [7:0] OFF_STATUS_ONE = 8'h22;
   localparam logic [7:0] OFF_STATUS_TWO = 8'h23;
   localparam logic [7:0] OFF_MASK_ONE   = 8'h24;
   localparam logic [7:0] OFF_MASK_TWO   = 8'h25;

   // reset values
   localparam logic [7:0] RST_EVENT  = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic [7:0] RST_MASK   = 8'hFF;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // positions in the 16-bit source vector: [15:8] group one, [7:0] group two
   localparam int POS_BUCK_OC  = 0;
   localparam int POS_REG1_OC  = 1;
   localparam int POS_REG4_OC  = 4;
   localparam int POS_UNDERV   = 5;
   localparam int POS_TWARN    = 6;
   localparam int POS_TSHUT    = 7;
   localparam int POS_BUCK_PG  = 8;
   localparam int POS_REG4_PG  = 12;
   localparam int POS_SPARE    = 13;
   localparam int POS_CLK_OK   = 14;
   localparam int POS_CLK_USE  = 15;

   // spare bit of group one never carries a live level
   localparam logic [15:0] LIVE_USED = 16'hDFFF;

   // serial bus: read/write flag value for a read
   localparam logic BUS_READ = 1'b1;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // sync chain reset: senses low, clock and data lines idle high
   localparam logic [17:0] SYNC_RST = 18'h30000;

   // live condition inputs, packed in register bit order
   typedef struct packed {
      logic       ext_clock_in_use_live;
      logic       ext_clock_valid_live;
      logic       spare_live;
      logic       reg4_pgood_live;
      logic       reg3_pgood_live;
      logic       reg2_pgood_live;
      logic       reg1_pgood_live;
      logic       buck_pgood_live;
      logic       thermal_shutdown_live;
      logic       thermal_warning_live;
      logic       undervoltage_live;
      logic       reg4_overcurrent_live;
      logic       reg3_overcurrent_live;
      logic       reg2_overcurrent_live;
      logic       reg1_overcurrent_live;
      logic       buck_overcurrent_live;
   } pes_sense_type;

   // serial slave sequencer
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_WR_ACK, ST_WDATA, ST_TX, ST_RACK
   } pes_bus_state_type;

endpackage : pes_pkg

// *** testbench/pes_event_sense_mask_tb_top.sv ***
// self-checking bench: live conditions, event latches, masks and interrupt
// assumes the host model as bus partner and the default slave address
`timescale 1ns/1ps
module pes_event_sense_mask_tb_top;
   localparam logic [6:0] DEV = 7'h10;   // slave address under test

   logic                   CLK;
   logic                   RST;
   pes_pkg::pes_sense_type SENSE_IN;
   logic                   SDA_OUT;
   logic                   SDA_OE_N;
   logic                   INT_N;
   logic                   scl;
   logic                   sda_low;
   logic                   sda;
   int                     n_mismatch;
   int                     cmp_count;
   logic [15:0]            old_sense;    // last applied conditions
   logic [15:0]            msk;          // mask one in [15:8], two in [7:0]
   logic [7:0]             rb [6];       // bytes of the last read
   logic                   ok;           // every byte acknowledged

   // open-drain wire with pull-up
   assign sda = (!SDA_OE_N ? SDA_OUT : 1'b1) & !sda_low;

   pes_event_sense_mask uut (
      .CLK      (CLK),
      .RST      (RST),
      .SENSE_IN (SENSE_IN),
      .SCL_IN   (scl),
      .SDA_IN   (sda),
      .SDA_OUT  (SDA_OUT),
      .SDA_OE_N (SDA_OE_N),
      .INT_N    (INT_N)
   );

   pes_host_model host (
      .clk     (CLK),
      .sda     (sda),
      .scl     (scl),
      .sda_low (sda_low)
   );

   // 40 MHz clock
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // write two bytes from register r on, pointer auto-increments
   task automatic wr(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1);
      logic a;
      ok = 1'b1;
      host.start;
      host.send({DEV, 1'b0}, a);
      ok &= a;
      host.send(r, a);
      ok &= a;
      host.send(d0, a);
      ok &= a;
      host.send(d1, a);
      ok &= a;
      host.stop;
      chk("write acks", {7'h00, ok}, 8'h01);
   endtask : wr

   // pointer write, repeated start, n bytes read
   task automatic rd(input logic [7:0] r, input int n);
      logic a;
      ok = 1'b1;
      host.start;
      host.send({DEV, 1'b0}, a);
      ok &= a;
      host.send(r, a);
      ok &= a;
      host.start;
      host.send({DEV, 1'b1}, a);
      ok &= a;
      for (int i = 0; i < n; i++) begin
         host.recv(i == n - 1, rb[i]);
      end
      host.stop;
      chk("read acks", {7'h00, ok}, 8'h01);
   endtask : rd

   // change the conditions, then check interrupt, events and live status
   task automatic apply(input logic [15:0] v);
      logic [15:0] ev;
      ev = (v ^ old_sense) & pes_pkg::LIVE_USED;
      @(posedge CLK);
      SENSE_IN <= v;
      host.wait_clk(12);
      chk("interrupt", {7'h00, INT_N}, {7'h00, ~|(ev & ~msk)});
      rd(pes_pkg::OFF_EVENT_ONE, 4);
      chk("event one", rb[0], ev[15:8]);
      chk("event two", rb[1], ev[7:0]);
      chk("status one", rb[2], v[15:8] & 8'hDF);
      chk("status two", rb[3], v[7:0]);
      host.wait_clk(2);
      chk("interrupt after clear", {7'h00, INT_N}, 8'h01);
      old_sense = v;
   endtask : apply

   // write both masks and read them back
   task automatic set_mask(input logic [15:0] m);
      wr(pes_pkg::OFF_MASK_ONE, m[15:8], m[7:0]);
      msk = m;
      rd(pes_pkg::OFF_MASK_ONE, 2);
      chk("mask one", rb[0], m[15:8]);
      chk("mask two", rb[1], m[7:0]);
   endtask : set_mask

   // cut a hang short; a clean run takes about 60k clocks
   initial begin
      repeat (90000) @(posedge CLK);
      n_mismatch++;
      final_report;
   end

   // main sequence
   initial begin
      logic a;
      RST = 1'b1;
      SENSE_IN = '0;
      old_sense = '0;
      msk = 16'hFFFF;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      repeat (6) @(posedge CLK);
      chk("interrupt at reset", {7'h00, INT_N}, 8'h01);
      // reset values of the whole map
      rd(pes_pkg::OFF_EVENT_ONE, 6);
      chk("reset event one", rb[0], 8'h00);
      chk("reset status one", rb[2], 8'h00);
      chk("reset mask one", rb[4], 8'hFF);
      chk("reset mask two", rb[5], 8'hFF);
      chk("reset event two", rb[1], 8'h00);
      chk("reset status two", rb[3], 8'h00);
      chk("data out level", {7'h00, SDA_OUT}, 8'h00);
      // foreign address gets no acknowledge
      host.start;
      host.send(8'h22, a);
      host.stop;
      chk("foreign address ack", {7'h00, a}, 8'h00);
      // status is read-only; unmapped place reads zero
      wr(pes_pkg::OFF_STATUS_ONE, 8'hFF, 8'hFF);
      rd(8'h30, 1);
      chk("unmapped read", rb[0], 8'h00);
      // everything masked: events latch but interrupt stays high
      apply(16'hFFFF);
      apply(16'h0000);
      // walk each source alone, half of them masked
      set_mask(16'h5AA5);
      for (int i = 0; i < 16; i++) begin
         apply(16'h0001 << i);
         apply(16'h0000);
      end
      // opposite masking, all enabled, then a second read clears nothing new
      set_mask(16'hA55A);
      apply(16'hA55A);
      apply(16'h5AA5);
      set_mask(16'h0000);
      apply(16'h0000);
      apply(16'h0000);
      // reset in mid-run brings the masks back to all ones
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      repeat (6) @(posedge CLK);
      chk("interrupt after mid-run reset", {7'h00, INT_N}, 8'h01);
      rd(pes_pkg::OFF_MASK_ONE, 2);
      chk("mid-run reset mask one", rb[0], 8'hFF);
      chk("mid-run reset mask two", rb[1], 8'hFF);
      final_report;
   end
endmodule : pes_event_sense_mask_tb_top

// *** testbench/pes_host_model.sv ***
// host controller model driving the two-wire register bus of the event block
// assumes a pulled-up data wire that the bench resolves from both parties
`timescale 1ns/1ps
module pes_host_model (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // clocks per bus clock phase, well above the two the slave filter needs
   localparam int HALF = 8;

   // lines released, bus clock idle high outside frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_clk

   // start or repeated start: data falls while bus clock high
   task automatic start;
      wait_clk(3);
      sda_low <= 1'b0;
      wait_clk(HALF);
      scl <= 1'b1;
      wait_clk(HALF);
      sda_low <= 1'b1;
      wait_clk(HALF);
      scl <= 1'b0;
   endtask : start

   // stop: data rises while bus clock high, then all released
   task automatic stop;
      wait_clk(3);
      sda_low <= 1'b1;
      wait_clk(HALF);
      scl <= 1'b1;
      wait_clk(HALF);
      sda_low <= 1'b0;
      wait_clk(HALF);
   endtask : stop

   // one bit; data moves 3 clocks after the fall so it never races the clock
   task automatic bit_io(input logic b_out, output logic b_in);
      wait_clk(3);
      sda_low <= !b_out;
      wait_clk(HALF);
      scl <= 1'b1;
      wait_clk(HALF / 2);
      b_in = sda;
      wait_clk(HALF / 2);
      scl <= 1'b0;
   endtask : bit_io

   // one byte out, msb first, then the slave's acknowledge
   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
      end
      bit_io(1'b1, b);
      ack = !b;
   endtask : send

   // one byte in; the last one of a read is refused to end it
   task automatic recv(input logic last, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b);
         d[i] = b;
      end
      bit_io(last, b);
   endtask : recv
endmodule : pes_host_model
